//--- verilog/ahs_pkg.sv
// Purpose: shared constants and types of the axis homing sequencer
// Assumes: one 50 MHz system clock, synchronous active-high reset
// Notes:   limits, fault codes and state codes are collected here
//
// Operation
// (R1) a rising enable starts homing; inputs are taken while enable is high
// (R2) module index 1 to 32; a non-pulse module raises error
// (R3) axis 1..2 on two-axis, 1..4 on four-axis modules, else error
// (R4) each axis owns one pulse and one direction output, in order
// (R5) mode 0 to 8 or 255 is legal; anything else raises error
// (R6) mode 0 clears the axis position with no pulses or sensors
// (R7) mode 1: sensor touch is origin, then leave sensor moving negative
// (R8) mode 2: sensor touch is origin, then leave sensor moving positive
// (R9) mode 3: mode 1, then count the configured Z-phase pulses
// (R10) mode 4: mode 2, then count the configured Z-phase pulses
// (R11) signed target speed gives homing rate; its sign is start direction
// (R12) speed magnitude 100..200000 Hz two-axis, 100..100000 four-axis
// (R13) mode 255 loads target speed value as the axis position
// (R14) approach rate 1 to 10000 Hz drives the slow final approach
// (R15) done rises once the axis output reaches home
// (R16) done falls when the axis is disabled or error rises
// (R17) error rises on runtime fault or illegal input, with a fault code
// (R18) error holds until enable falls
// (R19) the user wires the sensor inputs that the chosen mode needs
// (R20) direction output off moving positive, on moving negative
// (R21) done falls when enable falls after completed homing
// (R22) while error holds, no pulses and no done until a new start; pulse_out can still be high in the first error cycle of a runtime fault
package ahs_pkg;

  // ==========================================================
  // clock and rate generation
  localparam int unsigned CLK_HZ   = 50_000_000;
  localparam logic [27:0] ACC_WRAP = 28'h2FAF080;   // CLK_HZ, 28 bits

  // ==========================================================
  // parameter limits
  localparam logic [7:0]  MODULE_MIN    = 8'h01;
  localparam logic [7:0]  MODULE_MAX    = 8'h20;
  localparam logic [7:0]  AXIS_MIN      = 8'h01;
  localparam logic [7:0]  AXIS_MAX_TWO  = 8'h02;
  localparam logic [7:0]  AXIS_MAX_FOUR = 8'h04;
  localparam logic [15:0] MODE_CLEAR    = 16'h0000;
  localparam logic [15:0] MODE_DOG_NEG  = 16'h0001;
  localparam logic [15:0] MODE_DOG_POS  = 16'h0002;
  localparam logic [15:0] MODE_DOGZ_NEG = 16'h0003;
  localparam logic [15:0] MODE_DOGZ_POS = 16'h0004;
  localparam logic [15:0] MODE_RUN_MAX  = 16'h0008;
  localparam logic [15:0] MODE_LOAD     = 16'h00FF;
  localparam logic [32:0] RATE_MIN      = 33'h000000064;
  localparam logic [32:0] RATE_MAX_TWO  = 33'h000030D40;
  localparam logic [32:0] RATE_MAX_FOUR = 33'h0000186A0;
  localparam logic [15:0] JOG_MIN       = 16'h0001;
  localparam logic [15:0] JOG_MAX       = 16'h2710;

  // ==========================================================
  // reset values
  localparam logic [31:0] POS_RESET   = 32'h00000000;
  localparam logic [15:0] FAULT_NONE  = 16'h0000;

  // ==========================================================
  // fault codes
  localparam logic [15:0] FAULT_MODULE   = 16'h0001;
  localparam logic [15:0] FAULT_NOT_PU   = 16'h0002;
  localparam logic [15:0] FAULT_AXIS     = 16'h0003;
  localparam logic [15:0] FAULT_MODE     = 16'h0004;
  localparam logic [15:0] FAULT_SPEED    = 16'h0005;
  localparam logic [15:0] FAULT_JOG      = 16'h0006;
  localparam logic [15:0] FAULT_AXIS_OFF = 16'h0007;

  // ==========================================================
  // sequencer states
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_SEEK  = 6'h02,
    ST_LEAVE = 6'h04,
    ST_ZSEEK = 6'h08,
    ST_DONE  = 6'h10,
    ST_FAULT = 6'h20
  } ahs_state_e;

endpackage : ahs_pkg

//--- verilog/ahs_sync3.sv
// Purpose: three-stage synchroniser for one pin input
// Assumes: input is asynchronous to clk_sys
// Notes:   output follows only once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module ahs_sync3
  import ahs_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic pin,
  output logic      level
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic val;
  } ahs_sync_s;

  ahs_sync_s st;
  ahs_sync_s next_st;

  // shift chain; stage one feeds only stage two
  always_comb begin
    next_st    = st;
    next_st.s1 = pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (st.s2 == st.s3) begin
      next_st.val = st.s3;
    end
  end

  // register stage
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.val;

endmodule : ahs_sync3
`default_nettype wire

//--- verilog/ahs_rate_gen.sv
// Purpose: pulse train generator at a rate given in hertz
// Assumes: rate below half the clock rate
// Notes:   phase accumulator toggles at twice the rate; step on rise
`timescale 1ns/1ps
`default_nettype none
module ahs_rate_gen
  import ahs_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        run,
  input  wire logic [17:0] rate,
  output logic             pulse,
  output logic             step
);

  typedef struct packed {
    logic [27:0] acc;
    logic        pulse;
    logic        step;
  } ahs_gen_s;

  ahs_gen_s st;
  ahs_gen_s next_st;

  // accumulate twice the rate; each wrap is one half period
  always_comb begin
    logic [27:0] sum;
    sum          = st.acc + {9'h000, rate, 1'b0};
    next_st      = st;
    next_st.step = 1'b0;
    if (!run) begin
      next_st.acc   = '0;
      next_st.pulse = 1'b0;
    end else if (sum >= ACC_WRAP) begin
      next_st.acc   = sum - ACC_WRAP;
      next_st.pulse = ~st.pulse;
      next_st.step  = ~st.pulse;           // count on rising edge
    end else begin
      next_st.acc = sum;
    end
  end

  // register stage
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pulse = st.pulse;
  assign step  = st.step;

endmodule : ahs_rate_gen
`default_nettype wire

//--- verilog/ahs_home_axis_block.sv
// Purpose: homing sequencer for one pulse-output axis of a pulse module
// Assumes: sensor and Z-phase inputs are asynchronous pins, active high
// Notes:   no acceleration profile; rates switch in one step
`timescale 1ns/1ps
`default_nettype none
module ahs_home_axis_block
  import ahs_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               srst,
  input  wire logic               enable,
  input  wire logic [7:0]         module_index,
  input  wire logic [7:0]         axis_number,
  input  wire logic [15:0]        homing_mode,
  input  wire logic [31:0]        max_homing_rate,
  input  wire logic [15:0]        approach_rate,
  input  wire logic [31:0]        pulse_module_mask,
  input  wire logic [31:0]        four_axis_mask,
  input  wire logic [3:0]         axis_enabled,
  input  wire logic [7:0]         z_count_target,
  input  wire logic               near_home_sensor,
  input  wire logic               z_phase,
  output logic                    done,
  output logic                    error,
  output logic [15:0]             fault_code,
  output logic                    homing_busy,
  output logic [3:0]              pulse_out,
  output logic [3:0]              dir_out,
  output logic [3:0][31:0]        axis_position
);

  // ==========================================================
  // decode helpers

  // one-hot select of an axis from its zero-based index
  function automatic logic [3:0] ahs_axis_bit(input logic [1:0] idx);
    logic [3:0] r;
    r      = 4'h0;
    r[idx] = 1'b1;
    return r;
  endfunction : ahs_axis_bit

  // magnitude of the signed speed, wide enough for the most negative
  function automatic logic [32:0] ahs_mag(input logic [31:0] v);
    logic [32:0] r;
    r = v[31] ? (33'h000000000 - {v[31], v}) : {1'b0, v};
    return r;
  endfunction : ahs_mag

  // parameter check at start; returns FAULT_NONE when all legal
  function automatic logic [15:0] ahs_check(
    input logic [7:0]  mod_i,
    input logic [31:0] pu_mask,
    input logic [31:0] four_mask,
    input logic [7:0]  ax,
    input logic [15:0] md,
    input logic [31:0] spd,
    input logic [15:0] jog,
    input logic [3:0]  ax_en
  );
    logic [4:0]  slot;
    logic [7:0]  ax_max;
    logic [32:0] mag;
    logic [32:0] rmax;
    logic        motion;
    logic [15:0] r;
    slot   = 5'(mod_i - MODULE_MIN);
    ax_max = four_mask[slot] ? AXIS_MAX_FOUR : AXIS_MAX_TWO;
    rmax   = four_mask[slot] ? RATE_MAX_FOUR : RATE_MAX_TWO;
    mag    = ahs_mag(spd);
    motion = (md != MODE_CLEAR) && (md <= MODE_RUN_MAX);
    r      = FAULT_NONE;
    if ((mod_i < MODULE_MIN) || (mod_i > MODULE_MAX)) begin
      r = FAULT_MODULE;                                 // [R2]
    end else if (!pu_mask[slot]) begin
      r = FAULT_NOT_PU;                                 // [R2]
    end else if ((ax < AXIS_MIN) || (ax > ax_max)) begin
      r = FAULT_AXIS;                                   // [R3]
    end else if ((md > MODE_RUN_MAX) && (md != MODE_LOAD)) begin
      r = FAULT_MODE;                                   // [R5]
    end else if ((md <= MODE_RUN_MAX) &&
                 ((mag < RATE_MIN) || (mag > rmax))) begin
      r = FAULT_SPEED;                                  // [R12]
    end else if (motion && ((jog < JOG_MIN) || (jog > JOG_MAX))) begin
      r = FAULT_JOG;                                    // [R14]
    end else if (!ax_en[2'(ax - AXIS_MIN)]) begin
      r = FAULT_AXIS_OFF;                               // [R16]
    end
    return r;
  endfunction : ahs_check

  // ==========================================================
  // state

  typedef struct packed {
    ahs_state_e      state;
    logic [1:0]      axis_idx;
    logic [17:0]     run_rate;
    logic [17:0]     jog_rate;
    logic            dir_neg;
    logic            leave_neg;
    logic            z_wanted;
    logic [7:0]      z_cnt;
    logic            z_prev;
    logic            enable_prev;
    logic            done;
    logic            error;
    logic [15:0]     fault_code;
    logic [3:0]      pulse_out;
    logic [3:0]      dir_out;
    logic [3:0][31:0] pos;
  } ahs_main_s;

  ahs_main_s st;
  ahs_main_s next_st;

  logic        sensor_level;
  logic        z_level;
  logic        gen_run;
  logic        gen_pulse;
  logic        gen_step;
  logic        moving;
  logic [3:0]  sel_bit;

  // ==========================================================
  // pin synchronisers and pulse generator

  ahs_sync3 u_sync_sensor (
    .clk_sys (clk_sys),
    .srst    (srst),
    .pin     (near_home_sensor),
    .level   (sensor_level)
  );

  ahs_sync3 u_sync_z (
    .clk_sys (clk_sys),
    .srst    (srst),
    .pin     (z_phase),
    .level   (z_level)
  );

  // generator runs only in the moving states, so a fault stops it
  assign moving  = (st.state == ST_SEEK) || (st.state == ST_LEAVE) ||
                   (st.state == ST_ZSEEK);
  assign gen_run = moving;                              // [R22]
  assign sel_bit = ahs_axis_bit(st.axis_idx);

  ahs_rate_gen u_rate_gen (
    .clk_sys (clk_sys),
    .srst    (srst),
    .run     (gen_run),
    .rate    (st.run_rate),
    .pulse   (gen_pulse),
    .step    (gen_step)
  );

  // ==========================================================
  // sequencer

  always_comb begin
    logic        en_rise;
    logic        en_fall;
    logic        z_rise;
    logic        ax_on;
    logic [15:0] chk;
    logic [32:0] mag;
    logic [1:0]  new_idx;
    en_rise = enable & ~st.enable_prev;
    en_fall = ~enable & st.enable_prev;
    z_rise  = z_level & ~st.z_prev;
    ax_on   = |(axis_enabled & sel_bit);
    chk     = ahs_check(module_index, pulse_module_mask, four_axis_mask,
                        axis_number, homing_mode, max_homing_rate,
                        approach_rate, axis_enabled);
    mag     = ahs_mag(max_homing_rate);
    new_idx = 2'(axis_number - AXIS_MIN);

    next_st             = st;
    next_st.enable_prev = enable;
    next_st.z_prev      = z_level;

    // route the generator to the pulse output of the selected axis only
    for (int i = 0; i < 4; i++) begin
      next_st.pulse_out[i] = gen_pulse & sel_bit[i] & moving;   // [R4]
    end

    // count steps of the moving axis in its direction
    if (moving && gen_step) begin
      if (st.dir_neg) begin
        next_st.pos[st.axis_idx] = st.pos[st.axis_idx] - 32'h00000001;
      end else begin
        next_st.pos[st.axis_idx] = st.pos[st.axis_idx] + 32'h00000001;
      end
    end

    // a falling enable ends everything and clears both flags
    if (en_fall) begin
      next_st.state      = ST_IDLE;
      next_st.done       = 1'b0;                        // [R21]
      next_st.error      = 1'b0;                        // [R18]
      next_st.fault_code = FAULT_NONE;
      next_st.pulse_out  = 4'h0;
    end else begin
      unique case (st.state)
        ST_IDLE: begin
          if (en_rise) begin                            // [R1]
            next_st.axis_idx = new_idx;
            if (chk != FAULT_NONE) begin
              next_st.state      = ST_FAULT;
              next_st.error      = 1'b1;                // [R17]
              next_st.fault_code = chk;                 // [R17]
            end else if (homing_mode == MODE_CLEAR) begin
              next_st.pos[new_idx] = POS_RESET;         // [R6]
              next_st.done         = 1'b1;              // [R15]
              next_st.state        = ST_DONE;
            end else if (homing_mode == MODE_LOAD) begin
              next_st.pos[new_idx] = max_homing_rate;   // [R13]
              next_st.done         = 1'b1;              // [R15]
              next_st.state        = ST_DONE;
            end else begin
              // seek at the target rate in the sign's direction
              next_st.run_rate  = mag[17:0];            // [R11]
              next_st.dir_neg   = max_homing_rate[31];  // [R11]
              next_st.jog_rate  = {2'b00, approach_rate};
              next_st.z_wanted  = (homing_mode == MODE_DOGZ_NEG) ||
                                  (homing_mode == MODE_DOGZ_POS);
              if ((homing_mode == MODE_DOG_NEG) ||
                  (homing_mode == MODE_DOGZ_NEG)) begin
                next_st.leave_neg = 1'b1;               // [R7] [R9]
              end else if ((homing_mode == MODE_DOG_POS) ||
                           (homing_mode == MODE_DOGZ_POS)) begin
                next_st.leave_neg = 1'b0;               // [R8] [R10]
              end else begin
                next_st.leave_neg = max_homing_rate[31];
              end
              next_st.state = ST_SEEK;
            end
          end
        end
        ST_SEEK: begin
          if (!ax_on) begin
            next_st.state      = ST_FAULT;
            next_st.error      = 1'b1;                  // [R17]
            next_st.fault_code = FAULT_AXIS_OFF;
          end else if (sensor_level) begin
            // sensor touched: this point is the origin
            next_st.pos[st.axis_idx] = POS_RESET;       // [R7] [R8]
            next_st.dir_neg          = st.leave_neg;
            next_st.run_rate         = st.jog_rate;     // [R14]
            next_st.state            = ST_LEAVE;
          end
        end
        ST_LEAVE: begin
          if (!ax_on) begin
            next_st.state      = ST_FAULT;
            next_st.error      = 1'b1;                  // [R17]
            next_st.fault_code = FAULT_AXIS_OFF;
          end else if (!sensor_level) begin
            if (st.z_wanted && (z_count_target != 8'h00)) begin
              next_st.z_cnt = 8'h00;
              next_st.state = ST_ZSEEK;                 // [R9] [R10]
            end else begin
              next_st.done  = 1'b1;                     // [R15]
              next_st.state = ST_DONE;
            end
          end
        end
        ST_ZSEEK: begin
          if (!ax_on) begin
            next_st.state      = ST_FAULT;
            next_st.error      = 1'b1;                  // [R17]
            next_st.fault_code = FAULT_AXIS_OFF;
          end else if (z_rise) begin
            next_st.z_cnt = st.z_cnt + 8'h01;
            if ((st.z_cnt + 8'h01) == z_count_target) begin
              next_st.done  = 1'b1;                     // [R9] [R10]
              next_st.state = ST_DONE;
            end
          end
        end
        ST_DONE: begin
          // axis dropped out after homing: withdraw done
          if (!ax_on) begin
            next_st.done  = 1'b0;                       // [R16]
            next_st.state = ST_IDLE;
          end
        end
        ST_FAULT: begin
          next_st.done      = 1'b0;                     // [R16] [R22]
          next_st.error     = 1'b1;                     // [R18]
          next_st.pulse_out = 4'h0;                     // [R22]
        end
      endcase
    end

    // direction line of the moving axis follows its motion
    if (next_st.state inside {ST_SEEK, ST_LEAVE, ST_ZSEEK}) begin
      next_st.dir_out[next_st.axis_idx] = next_st.dir_neg;  // [R20]
    end
  end

  // register stage
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st       <= '0;
      st.state <= ST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs from flops; homing_busy decoded from the state

  assign done          = st.done;
  assign error         = st.error;
  assign fault_code    = st.fault_code;
  assign homing_busy   = moving;
  assign pulse_out     = st.pulse_out;
  assign dir_out       = st.dir_out;
  assign axis_position = st.pos;

endmodule : ahs_home_axis_block
`default_nettype wire

//--- tb/ahs_home_axis_block_properties.sv
// Purpose: port-level checks of the homing sequencer
// Assumes: one clock domain, srst synchronous active high
// Notes:   bound into every instance of the top module
`timescale 1ns/1ps
`default_nettype none
module ahs_home_axis_block_properties
  import ahs_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic        enable,
  input wire logic [7:0]  axis_number,
  input wire logic [15:0] homing_mode,
  input wire logic [3:0]  axis_enabled,
  input wire logic        done,
  input wire logic        error,
  input wire logic [15:0] fault_code,
  input wire logic        homing_busy,
  input wire logic [3:0]  pulse_out
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  // ==========================================================
  // selected axis as index and one-hot mask
  logic [1:0] ax;
  logic [3:0] sel;
  assign ax  = axis_number[1:0] - 2'h1;
  assign sel = 4'h1 << ax;

  // start and end of an operation
  sequence s_start;
    enable && !$past(enable);
  endsequence
  sequence s_fall;
    $past(enable) && !enable;
  endsequence

  // ==========================================================
  // assertions
  a_start_motion : assert property (s_start and
    homing_mode >= 16'h0001 && homing_mode <= MODE_RUN_MAX |=>
    homing_busy || error)
    else $error("motion start gave neither busy nor error");
  a_mode_bad : assert property (s_start and
    homing_mode > MODE_RUN_MAX && homing_mode != MODE_LOAD |=> error)
    else $error("illegal mode accepted");
  a_quick_done : assert property (s_start and
    (homing_mode == MODE_CLEAR || homing_mode == MODE_LOAD) |=> done || error)
    else $error("clear or load did not finish at once");
  a_err_no_done : assert property (error |-> !done)
    else $error("done high while error");
  a_axis_drop : assert property (done && !(|(axis_enabled & sel))
    |=> !done)
    else $error("done held on disabled axis");
  a_code_set : assert property (error |-> fault_code != FAULT_NONE)
    else $error("error without fault code");
  a_err_sticky : assert property (error && enable |=> error)
    else $error("error dropped while enable high");
  a_fall_clear : assert property (s_fall |=> !error && !done &&
    fault_code == FAULT_NONE && !homing_busy)
    else $error("outputs not cleared after enable fall");
  a_err_quiet : assert property (error && $past(error) |->
    pulse_out == 4'h0 && !homing_busy)
    else $error("pulses while error");
  a_one_axis : assert property (homing_busy && $past(homing_busy) |->
    ((pulse_out ^ $past(pulse_out)) & ~sel) == 4'h0)
    else $error("unselected axis pulsed");
endmodule : ahs_home_axis_block_properties

bind ahs_home_axis_block ahs_home_axis_block_properties i_props (
  .clk_sys, .srst, .enable, .axis_number, .homing_mode, .axis_enabled,
  .done, .error, .fault_code, .homing_busy, .pulse_out
);
`default_nettype wire

//--- tb/ahs_drive_model.sv
// Purpose: drive and axis model with home sensor and Z marker
// Assumes: one step per rising pulse, direction high is negative
// Notes:   sensor and marker are decoded from the model position
`timescale 1ns/1ps
`default_nettype none
module ahs_drive_model #(
  parameter int SENS_LO = 0,
  parameter int SENS_HI = 2,
  parameter int Z_AT    = -3
) (
  input wire logic        clk_sys,
  input wire logic        load,
  input wire logic [31:0] load_pos,
  input wire logic        step_in,
  input wire logic        dir_in,
  output logic            sensor,
  output logic            zpulse,
  output var int          pos
);
  logic step_q;

  // count steps in the commanded direction
  initial pos = 100;
  always @(posedge clk_sys) begin
    step_q <= step_in;
    if (load) begin
      pos <= load_pos;
    end else if (step_in && !step_q) begin
      pos <= dir_in ? pos - 1 : pos + 1;
    end
  end

  // sensor wired to the axis that is homed
  assign sensor = (pos >= SENS_LO) && (pos <= SENS_HI);
  assign zpulse = (pos == Z_AT);
endmodule : ahs_drive_model
`default_nettype wire

//--- tb/ahs_home_axis_block_tb_top.sv
// Purpose: self-checking bench of the homing sequencer
// Assumes: slot 1 two-axis, slot 3 four-axis, slot 2 not pulse
// Notes:   table of instant outcomes, then motion and fault tests
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, a, b); end end
module ahs_home_axis_block_tb_top;
  import ahs_pkg::*;
  typedef struct packed {
    logic [7:0]  m;
    logic [7:0]  a;
    logic [15:0] md;
    logic [31:0] s;
    logic [15:0] j;
    logic [15:0] c;
  } ahs_row_s;
  logic clk_sys, srst, enable, done, error, homing_busy, load;
  logic [7:0]  module_index, axis_number, z_count_target;
  logic [15:0] homing_mode, approach_rate, fault_code;
  logic [31:0] max_homing_rate, pulse_module_mask, four_axis_mask;
  logic [31:0] load_pos;
  logic [3:0]  axis_enabled, pulse_out, dir_out;
  logic [3:0][31:0] axis_position;
  logic near_home_sensor, z_phase;
  int model_pos;
  int n_fail = 0;
  int total_checks = 0;
  ahs_row_s rows [16] = '{
    '{8'h01, 8'h02, 16'h00FF, 32'hFFFFFFF9, 16'h0064, 16'h0000},
    '{8'h01, 8'h02, 16'h0000, 32'h00000064, 16'h0064, 16'h0000},
    '{8'h00, 8'h01, 16'h0000, 32'h00000064, 16'h0064, 16'h0001},
    '{8'h21, 8'h01, 16'h0000, 32'h00000064, 16'h0064, 16'h0001},
    '{8'h02, 8'h01, 16'h0000, 32'h00000064, 16'h0064, 16'h0002},
    '{8'h20, 8'h01, 16'h0000, 32'h00000064, 16'h0064, 16'h0002},
    '{8'h01, 8'h03, 16'h0000, 32'h00000064, 16'h0064, 16'h0003},
    '{8'h03, 8'h04, 16'h0000, 32'h000186A0, 16'h0064, 16'h0000},
    '{8'h03, 8'h05, 16'h0000, 32'h00000064, 16'h0064, 16'h0003},
    '{8'h01, 8'h01, 16'h0009, 32'h00000064, 16'h0064, 16'h0004},
    '{8'h01, 8'h01, 16'h0000, 32'h00000063, 16'h0064, 16'h0005},
    '{8'h01, 8'h01, 16'h0000, 32'hFFFCF2C0, 16'h0064, 16'h0000},
    '{8'h01, 8'h01, 16'h0000, 32'hFFFCF2BF, 16'h0064, 16'h0005},
    '{8'h03, 8'h01, 16'h0000, 32'h000186A1, 16'h0064, 16'h0005},
    '{8'h01, 8'h01, 16'h0001, 32'h00000064, 16'h0000, 16'h0006},
    '{8'h01, 8'h01, 16'h0002, 32'h00000064, 16'h2711, 16'h0006}};

  // ==========================================================
  // design and drive model
  ahs_home_axis_block i_ahs_home_axis_block (.clk_sys, .srst, .enable,
    .module_index, .axis_number, .homing_mode, .max_homing_rate,
    .approach_rate, .pulse_module_mask, .four_axis_mask, .axis_enabled,
    .z_count_target, .near_home_sensor, .z_phase, .done, .error,
    .fault_code, .homing_busy, .pulse_out, .dir_out, .axis_position);
  ahs_drive_model i_ahs_drive_model (.clk_sys, .load, .load_pos,
    .step_in(pulse_out[0]), .dir_in(dir_out[0]),
    .sensor(near_home_sensor), .zpulse(z_phase), .pos(model_pos));

  // clock source
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // tasks
  task automatic results;
    $display("checks=%0d fails=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  task automatic op(input ahs_row_s r);
    @(posedge clk_sys);
    module_index    <= r.m;
    axis_number     <= r.a;
    homing_mode     <= r.md;
    max_homing_rate <= r.s;
    approach_rate   <= r.j;
    enable          <= 1'b1;
  endtask : op

  task automatic stop;
    @(posedge clk_sys);
    enable <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK({done, error, fault_code}, 18'h0)
    $display("test end t=%0t fails=%0d", $time, n_fail);
  endtask : stop

  task automatic wait_end(input int lim);
    int k;
    k = 0;
    while (done !== 1'b1 && error !== 1'b1 && k < lim) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    if (k >= lim) begin
      n_fail++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, k, lim);
      results();
    end
  endtask : wait_end

  task automatic motion(input logic [15:0] md, input logic [31:0] s,
    input int p0, input logic [7:0] zt, input int pm, input logic [31:0] pe);
    @(posedge clk_sys);
    load           <= 1'b1;
    load_pos       <= p0;
    z_count_target <= zt;
    @(posedge clk_sys);
    load <= 1'b0;
    repeat (8) @(posedge clk_sys);
    op('{8'h01, 8'h01, md, s, 16'h2710, 16'h0000});
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK({homing_busy, dir_out[0]}, {1'b1, s[31]})
    wait_end(80000);
    `CHK({done, error, homing_busy}, 3'b100)
    `CHK(model_pos, pm)
    `CHK(axis_position[0], pe)
    stop();
  endtask : motion

  // ==========================================================
  // main sequence
  initial begin : main
    ahs_row_s r;
    int i;
    srst = 1'b1;
    enable = 1'b0;
    load = 1'b0;
    load_pos = 32'h0;
    module_index = 8'h01;
    axis_number = 8'h01;
    homing_mode = 16'h0000;
    max_homing_rate = 32'h00000064;
    approach_rate = 16'h0064;
    pulse_module_mask = 32'h00000005;
    four_axis_mask = 32'h00000004;
    axis_enabled = 4'hF;
    z_count_target = 8'h00;
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    #1;
    `CHK({done, error, fault_code, homing_busy, pulse_out}, 23'h0)
    `CHK(axis_position, 128'h0)
    // table of instant outcomes
    for (i = 0; i < 16; i++) begin
      r = rows[i];
      op(r);
      repeat (4) @(posedge clk_sys);
      #1;
      `CHK({done, error, fault_code},
        {r.c == 16'h0, r.c != 16'h0, r.c})
      if (r.c == 16'h0) begin
        `CHK(axis_position[r.a[1:0] - 2'h1],
          (r.md == MODE_LOAD) ? r.s : 32'h0)
      end
      stop();
    end
    // homing moves against the drive model
    motion(16'h0001, 32'hFFFE7960, 4, 8'h00, -1, 32'hFFFFFFFD);
    motion(16'h0002, 32'h000186A0, -2, 8'h00, 3, 32'h00000003);
    motion(16'h0003, 32'hFFFE7960, 4, 8'h01, -3, 32'hFFFFFFFB);
    motion(16'h0004, 32'hFFFE7960, 4, 8'h00, 3, 32'h00000001);
    // axis disabled in mid-move raises error
    op('{8'h01, 8'h01, 16'h0002, 32'h000186A0, 16'h2710, 16'h0000});
    repeat (10) @(posedge clk_sys);
    axis_enabled <= 4'hE;
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK({done, error, fault_code}, {2'b01, FAULT_AXIS_OFF})
    @(posedge clk_sys);
    axis_enabled <= 4'hF;
    stop();
    // axis disabled after done drops done
    op('{8'h01, 8'h01, 16'h0000, 32'h00000064, 16'h0064, 16'h0000});
    repeat (3) @(posedge clk_sys);
    axis_enabled <= 4'hE;
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK({done, error}, 2'b00)
    @(posedge clk_sys);
    axis_enabled <= 4'hF;
    stop();
    results();
  end
endmodule : ahs_home_axis_block_tb_top
`default_nettype wire
